// ### verilog/pdac_partial_ctrl.sv
// Module: partial display area control with Avalon-MM register slave
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
// Function
// - Each area starts at its own start line
// - Count of one gives one-line area
// - Count zero means no area, normal display
// - Lines outside areas show off-area colour
// - Second area only when first count nonzero
// - Overlapping second area is ignored entirely
// - Partial mode drops scroll writes, no scroll
// - Count is taken directly as lines
module pdac_partial_ctrl #(
	parameter int unsigned LINE_W = pdac_pkg::PDAC_LINE_W,
	parameter int unsigned PIX_W = pdac_pkg::PDAC_PIX_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [pdac_pkg::PDAC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [pdac_pkg::PDAC_DATA_W-1:0] avs_writedata,
	output logic [pdac_pkg::PDAC_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic line_valid,
	input wire logic [LINE_W-1:0] line_num,
	input wire logic [PIX_W-1:0] pix_in,
	output logic [PIX_W-1:0] pix_out,
	output logic pix_valid,
	output logic line_shown,
	output logic [LINE_W-1:0] scroll_step
);
	import pdac_pkg::*;

	// ----------------------------------------
	// Area arithmetic
	// ----------------------------------------
	// One extra bit so start plus count never wraps past the last line
	function automatic logic [LINE_W:0] area_end(input logic [LINE_W-1:0] s,
		input logic [LINE_W-1:0] c);
		area_end = {1'b0, s} + {1'b0, c};
	endfunction

	function automatic logic in_area(input logic [LINE_W-1:0] l,
		input logic [LINE_W-1:0] s, input logic [LINE_W-1:0] c);
		in_area = ({1'b0, l} >= {1'b0, s}) && ({1'b0, l} < area_end(s, c));
	endfunction

	logic partial_en_r;
	logic [LINE_W-1:0] a1_start_r;
	logic [LINE_W-1:0] a2_start_r;
	logic [LINE_W-1:0] a1_count_r;
	logic [LINE_W-1:0] a2_count_r;
	logic [PIX_W-1:0] colour_r;
	logic [LINE_W-1:0] scroll_r;
	logic [pdac_pkg::PDAC_DATA_W-1:0] rdata_nxt;
	logic [pdac_pkg::PDAC_DATA_W-1:0] readdata_r;
	logic waitreq_r;
	logic wr_commit;
	logic a1_on;
	logic overlap;
	logic a2_on;
	logic partial_active;
	logic show_line;
	logic [PIX_W-1:0] pix_r;
	logic pix_valid_r;
	logic shown_r;

	// ----------------------------------------
	// Area decisions
	// ----------------------------------------
	assign a1_on = (a1_count_r != PDAC_COUNT_NONE);
	assign partial_active = partial_en_r && a1_on;
	// Intervals [s,e) intersect when each starts before the other ends
	assign overlap = ({1'b0, a2_start_r} < area_end(a1_start_r, a1_count_r)) &&
		({1'b0, a1_start_r} < area_end(a2_start_r, a2_count_r));
	assign a2_on = a1_on && (a2_count_r != PDAC_COUNT_NONE) && !overlap;
	assign show_line = !partial_active || in_area(line_num, a1_start_r, a1_count_r) ||
		(a2_on && in_area(line_num, a2_start_r, a2_count_r));

	// ----------------------------------------
	// Avalon-MM slave: one wait cycle per access
	// ----------------------------------------
	assign wr_commit = avs_write && !waitreq_r;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			waitreq_r <= 1'b1;
		end else if (!waitreq_r) begin
			waitreq_r <= 1'b1;
		end else if (avs_read || avs_write) begin
			waitreq_r <= 1'b0;
		end
	end

	always_comb begin
		rdata_nxt = '0;
		case (avs_address)
			PDAC_OFF_CTRL: rdata_nxt[PDAC_CTRL_PARTIAL_BIT] = partial_en_r;
			PDAC_OFF_A1_START: rdata_nxt[LINE_W-1:0] = a1_start_r;
			PDAC_OFF_A2_START: rdata_nxt[LINE_W-1:0] = a2_start_r;
			PDAC_OFF_A1_COUNT: rdata_nxt[LINE_W-1:0] = a1_count_r;
			PDAC_OFF_A2_COUNT: rdata_nxt[LINE_W-1:0] = a2_count_r;
			PDAC_OFF_COLOUR: rdata_nxt[PIX_W-1:0] = colour_r;
			PDAC_OFF_SCROLL: rdata_nxt[LINE_W-1:0] = scroll_r;
			PDAC_OFF_STATUS: begin
				rdata_nxt[PDAC_ST_ACTIVE_BIT] = partial_active;
				rdata_nxt[PDAC_ST_A2_BIT] = a2_on;
				rdata_nxt[PDAC_ST_INAREA_BIT] = shown_r;
			end
			default: rdata_nxt = '0;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			readdata_r <= '0;
		end else if (avs_read && waitreq_r) begin
			readdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			partial_en_r <= 1'b0;
			a1_start_r <= PDAC_LINE_RST;
			a2_start_r <= PDAC_LINE_RST;
			a1_count_r <= PDAC_COUNT_NONE;
			a2_count_r <= PDAC_COUNT_NONE;
			colour_r <= PDAC_COLOUR_RST;
		end else if (wr_commit) begin
			case (avs_address)
				PDAC_OFF_CTRL: partial_en_r <= avs_writedata[PDAC_CTRL_PARTIAL_BIT];
				PDAC_OFF_A1_START: a1_start_r <= avs_writedata[LINE_W-1:0];
				PDAC_OFF_A2_START: a2_start_r <= avs_writedata[LINE_W-1:0];
				PDAC_OFF_A1_COUNT: a1_count_r <= avs_writedata[LINE_W-1:0];
				PDAC_OFF_A2_COUNT: a2_count_r <= avs_writedata[LINE_W-1:0];
				PDAC_OFF_COLOUR: colour_r <= avs_writedata[PIX_W-1:0];
				default: ;
			endcase
		end
	end

	// Scroll step kept apart: its write is dropped while partial mode runs
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scroll_r <= PDAC_LINE_RST;
		end else if (wr_commit && (avs_address == PDAC_OFF_SCROLL) && !partial_active) begin
			scroll_r <= avs_writedata[LINE_W-1:0];
		end
	end

	// ----------------------------------------
	// Line and pixel path, one register stage
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pix_r <= PDAC_COLOUR_RST;
			pix_valid_r <= 1'b0;
			shown_r <= 1'b0;
		end else begin
			pix_valid_r <= line_valid;
			if (line_valid) begin
				shown_r <= show_line;
				pix_r <= show_line ? pix_in : colour_r;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scroll_step <= PDAC_LINE_RST;
		end else begin
			scroll_step <= partial_active ? PDAC_LINE_RST : scroll_r;
		end
	end

	assign avs_readdata = readdata_r;
	assign avs_waitrequest = waitreq_r;
	assign pix_out = pix_r;
	assign pix_valid = pix_valid_r;
	assign line_shown = shown_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_req_seen;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ack;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	property p_one_wait;
		s_req_seen |=> s_ack;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("bus answer not one cycle later");

	property p_offcolour;
		line_valid && partial_active && !in_area(line_num, a1_start_r, a1_count_r) &&
			!(a2_on && in_area(line_num, a2_start_r, a2_count_r))
			|=> pix_out == $past(colour_r);
	endproperty
	a_offcolour: assert property (p_offcolour) else $error("off line not coloured");

	property p_normal;
		line_valid && !partial_active |=> line_shown && pix_out == $past(pix_in);
	endproperty
	a_normal: assert property (p_normal) else $error("normal line altered");

	property p_a1_line;
		line_valid && partial_active && line_num == a1_start_r |=> line_shown;
	endproperty
	a_a1_line: assert property (p_a1_line) else $error("area start not shown");

	property p_one_tall;
		line_valid && partial_active && a1_count_r == 8'h01 &&
			line_num == a1_start_r + 8'h01 && !a2_on |=> !line_shown;
	endproperty
	a_one_tall: assert property (p_one_tall) else $error("one-line area too tall");

	// Area two set up alone must leave every line as display data
	property p_a2_gate;
		line_valid && a1_count_r == PDAC_COUNT_NONE && a2_count_r != PDAC_COUNT_NONE
			|=> line_shown && pix_out == $past(pix_in);
	endproperty
	a_a2_gate: assert property (p_a2_gate) else $error("second area without first");

	property p_overlap;
		line_valid && partial_active && overlap &&
			!in_area(line_num, a1_start_r, a1_count_r) |=> !line_shown;
	endproperty
	a_overlap: assert property (p_overlap) else $error("overlapping second area used");

	property p_scroll_drop;
		partial_active && wr_commit && avs_address == PDAC_OFF_SCROLL |=> $stable(scroll_r);
	endproperty
	a_scroll_drop: assert property (p_scroll_drop) else $error("scroll write taken");

	property p_no_scroll;
		partial_active ##1 partial_active |-> scroll_step == PDAC_LINE_RST;
	endproperty
	a_no_scroll: assert property (p_no_scroll) else $error("scroll during partial");

	property p_count_lines;
		line_valid && partial_active && !a2_on &&
			{1'b0, line_num} == area_end(a1_start_r, a1_count_r) - 9'h001 |=> line_shown;
	endproperty
	a_count_lines: assert property (p_count_lines) else $error("last area line lost");
endmodule

// ### verilog/pdac_pkg.sv
// Package: register map, field layout and reset values of the partial area control
package pdac_pkg;
	localparam int unsigned PDAC_ADDR_W = 5;
	localparam int unsigned PDAC_DATA_W = 32;
	localparam int unsigned PDAC_LINE_W = 8;
	localparam int unsigned PDAC_PIX_W = 16;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [PDAC_ADDR_W-1:0] PDAC_OFF_CTRL = 5'h00;
	localparam logic [PDAC_ADDR_W-1:0] PDAC_OFF_A1_START = 5'h04;
	localparam logic [PDAC_ADDR_W-1:0] PDAC_OFF_A2_START = 5'h08;
	localparam logic [PDAC_ADDR_W-1:0] PDAC_OFF_A1_COUNT = 5'h0C;
	localparam logic [PDAC_ADDR_W-1:0] PDAC_OFF_A2_COUNT = 5'h10;
	localparam logic [PDAC_ADDR_W-1:0] PDAC_OFF_COLOUR = 5'h14;
	localparam logic [PDAC_ADDR_W-1:0] PDAC_OFF_SCROLL = 5'h18;
	localparam logic [PDAC_ADDR_W-1:0] PDAC_OFF_STATUS = 5'h1C;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int unsigned PDAC_CTRL_PARTIAL_BIT = 0;
	localparam int unsigned PDAC_ST_ACTIVE_BIT = 0;
	localparam int unsigned PDAC_ST_A2_BIT = 1;
	localparam int unsigned PDAC_ST_INAREA_BIT = 2;
	localparam logic [PDAC_LINE_W-1:0] PDAC_LINE_RST = 8'h00;
	localparam logic [PDAC_PIX_W-1:0] PDAC_COLOUR_RST = 16'h0000;
	localparam logic [PDAC_LINE_W-1:0] PDAC_COUNT_NONE = 8'h00;
endpackage

// ### tb/pdac_host.sv
// Host processor model: register bus master for the partial area control
`timescale 1ns/1ps
module pdac_host import pdac_pkg::*; (
	input wire logic ref_clk,
	output logic [pdac_pkg::PDAC_ADDR_W-1:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [pdac_pkg::PDAC_DATA_W-1:0] avs_writedata,
	input wire logic [pdac_pkg::PDAC_DATA_W-1:0] avs_readdata,
	input wire logic avs_waitrequest
);
	initial begin
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
	end
	// ----------------------------------------
	// One bus access, held until the slave answers
	// ----------------------------------------
	task automatic xfer(input logic rd, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge ref_clk);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= !rd;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// Released lines do not keep the old value
		avs_address <= ~a;
		avs_writedata <= ~d;
		if (avs_waitrequest !== 1'b0)
			tb.hang();
	endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the partial area control block
`timescale 1ns/1ps
module tb;
	import pdac_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic line_valid = 1'b0;
	logic [7:0] line_num = 8'h00;
	logic [15:0] pix_in = 16'h0000;
	logic [4:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest, pix_valid, line_shown;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [15:0] pix_out;
	logic [7:0] scroll_step;
	int mismatches = 0;
	int compares = 0;
	int en, s1, c1, s2, c2, col;
	bit shown_last = 1'b0;
	int cc[8][5] = '{'{1, 8'h58, 1, 0, 0}, '{1, 8'h10, 0, 8'h10, 8'h20}, '{0, 8'h10, 8'h20, 0, 0},
		'{1, 0, 8'h58, 8'h84, 8'h2B}, '{1, 8'h2C, 8'h58, 8'h58, 8'h10},
		'{1, 0, 8'h58, 8'h58, 8'h58}, '{1, 8'hAF, 8'hAF, 0, 1},
		'{1, 8'h2C, 8'h58, 8'h58, 8'h58}};
	always #4 ref_clk = ~ref_clk;
	pdac_partial_ctrl DUT (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .line_valid, .line_num, .pix_in, .pix_out, .pix_valid,
		.line_shown, .scroll_step);
	pdac_host host (.ref_clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest);
	// ----------------------------------------
	// Expectation, checks and stimulus helpers
	// ----------------------------------------
	function automatic bit in_area(int l, int s, int c);
		return l >= s && l < s + c;
	endfunction
	function automatic bit a2_exp();
		return c1 != 0 && c2 != 0 && !(s1 < s2 + c2 && s2 < s1 + c1);
	endfunction
	function automatic bit shown(int l);
		return !(en != 0 && c1 != 0) || in_area(l, s1, c1) || (a2_exp() && in_area(l, s2, c2));
	endfunction
	// Status word: partial active, area two in use, last line shown
	function automatic logic [31:0] status_exp();
		return {29'b0, shown_last, a2_exp(), en != 0 && c1 != 0};
	endfunction
	task automatic chk_pix(logic [15:0] got, logic [15:0] exp, string m);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic chk_reg(logic [31:0] got, logic [31:0] exp, string m);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic cfg(int e, int a, int b, int c, int d);
		en = e;
		s1 = a;
		c1 = b;
		s2 = c;
		c2 = d;
		col = $urandom % 32'h10000;
		host.xfer(1'b0, PDAC_OFF_A1_START, 32'(a), q);
		host.xfer(1'b0, PDAC_OFF_A2_START, 32'(c), q);
		host.xfer(1'b0, PDAC_OFF_A1_COUNT, 32'(b), q);
		host.xfer(1'b0, PDAC_OFF_A2_COUNT, 32'(d), q);
		host.xfer(1'b0, PDAC_OFF_COLOUR, 32'(col), q);
		host.xfer(1'b0, PDAC_OFF_CTRL, 32'(e), q);
		host.xfer(1'b1, PDAC_OFF_COLOUR, 32'h0, q);
		chk_reg(q, 32'(col), "colour readback");
		host.xfer(1'b1, PDAC_OFF_STATUS, 32'h0, q);
		chk_reg(q, status_exp(), "status");
	endtask
	task automatic line(int l);
		logic [15:0] p;
		p = 16'($urandom);
		@(posedge ref_clk);
		line_valid <= 1'b1;
		line_num <= 8'(l);
		pix_in <= p;
		#1;
		chk_reg({31'b0, pix_valid}, 32'h0, "valid idle");
		@(posedge ref_clk);
		line_valid <= 1'b0;
		#1;
		chk_pix(pix_out, shown(l) ? p : 16'(col), "pixel");
		chk_reg({31'b0, line_shown}, 32'(shown(l)), "shown");
		chk_reg({31'b0, pix_valid}, 32'h1, "valid");
		shown_last = shown(l);
	endtask
	// Edges of both areas plus one random line
	task automatic probe();
		int pts[$];
		pts = '{s1 - 1, s1, s1 + c1 - 1, s1 + c1, s2 - 1, s2, s2 + c2 - 1, s2 + c2, $urandom % 176};
		foreach (pts[i])
			if (pts[i] >= 0 && pts[i] < 256)
				line(pts[i]);
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic hang();
		mismatches++;
		stop_test();
	endtask
	initial begin
		void'($urandom(32'h9cd6));
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		host.xfer(1'b0, 5'h02, 32'hFFFF_FFFF, q);
		for (int a = 0; a < 32; a += 2) begin
			host.xfer(1'b1, 5'(a), 32'h0, q);
			chk_reg(q, 32'h0, "reset or unmapped read");
		end
		$display("test reset done");
		foreach (cc[i]) begin
			cfg(cc[i][0], cc[i][1], cc[i][2], cc[i][3], cc[i][4]);
			probe();
		end
		repeat (30) begin
			cfg($urandom % 2, $urandom % 176, $urandom % 176, $urandom % 176, $urandom % 176);
			probe();
		end
		$display("test areas done");
		cfg(0, 0, 0, 0, 0);
		host.xfer(1'b0, PDAC_OFF_SCROLL, 32'h5, q);
		host.xfer(1'b1, PDAC_OFF_SCROLL, 32'h0, q);
		chk_reg({24'b0, scroll_step}, 32'h5, "scroll idle");
		cfg(1, 8'h0A, 8'h14, 0, 0);
		host.xfer(1'b0, PDAC_OFF_SCROLL, 32'h9, q);
		host.xfer(1'b1, PDAC_OFF_SCROLL, 32'h0, q);
		chk_reg(q, 32'h5, "scroll write kept out");
		chk_reg({24'b0, scroll_step}, 32'h0, "scroll in partial");
		cfg(0, 8'h0A, 8'h14, 0, 0);
		host.xfer(1'b1, PDAC_OFF_SCROLL, 32'h0, q);
		chk_reg({24'b0, scroll_step}, 32'h5, "scroll restored");
		$display("test scroll done");
		// Reset again in mid-run: settings in use must fall back
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		host.xfer(1'b1, PDAC_OFF_SCROLL, 32'h0, q);
		chk_reg(q, 32'(PDAC_LINE_RST), "scroll after reset");
		chk_reg({24'b0, scroll_step}, 32'(PDAC_LINE_RST), "step after reset");
		host.xfer(1'b1, PDAC_OFF_A1_COUNT, 32'h0, q);
		chk_reg(q, 32'(PDAC_COUNT_NONE), "count after reset");
		chk_pix(pix_out, PDAC_COLOUR_RST, "pixel after reset");
		$display("test second reset done");
		stop_test();
	end
endmodule
